// file: tgu_partner.sv
// far side model: event source, output watcher, reset counter
`timescale 1ns/1ns
`default_nettype none
module tgu_partner (
  input  wire logic MCLK,
  input  wire logic out_pin,
  input  wire logic sys_rst,
  output var  logic in_pin
);
  logic [15:0] gap     = '0;    // cycles between the last two output changes
  logic [15:0] run     = '0;    // cycles since the last output change
  logic        last    = 1'b1;  // output level at the previous edge
  logic [15:0] rst_cnt = '0;    // system reset pulses seen
  initial in_pin = 1'b1;
  // measure output period and count reset pulses
  always @(posedge MCLK) begin
    run  <= run + 16'h1;
    last <= out_pin;
    if (out_pin !== last) begin
      gap <= run + 16'h1;
      run <= '0;
    end
    if (sys_rst === 1'b1) begin
      rst_cnt <= rst_cnt + 16'h1;
    end
  end
  // static input level
  task automatic lvl(input logic b);
    @(posedge MCLK);
    in_pin <= b;
  endtask
  // falling edges ten clocks apart, gate period ten clocks
  task automatic fall(input int n);
    repeat (n) begin
      @(posedge MCLK);
      in_pin <= 1'b0;
      repeat (5) @(posedge MCLK);
      in_pin <= 1'b1;
      repeat (4) @(posedge MCLK);
    end
  endtask
endmodule
`default_nettype wire

// file: tgu_pkg.sv
// package: register map, field positions, reset values and types of the timer/guard unit
package tgu_pkg;

  // register word offsets (byte addresses on the avalon bus)
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h0;
  localparam logic [3:0] OFS_COUNT_LOW  = 4'h4;
  localparam logic [3:0] OFS_PRESCALE   = 4'h8;
  localparam logic [3:0] OFS_CONTROL    = 4'hC;
  // guard control word and interrupt routing word
  localparam logic [4:0] OFS_GUARD      = 5'h10;
  localparam logic [4:0] OFS_ROUTE      = 5'h14;

  // control register field positions
  localparam int BIT_RUN      = 7;
  localparam int BIT_SINGLE   = 6;
  localparam int BIT_MODE_HI  = 5;
  localparam int BIT_MODE_LO  = 4;
  localparam int BIT_IN_EN    = 3;
  localparam int BIT_OUT_MODE = 2;
  localparam int BIT_WR_OUT   = 1;
  localparam int BIT_OUT_EN   = 0;
  // guard word: enable bit, active low
  localparam int BIT_GUARD_EN_N = 6;
  // routing word
  localparam int BIT_TOP_SEL = 2;
  localparam int BIT_A0_SEL  = 1;

  // reset values
  localparam logic [7:0]  RST_COUNT_HIGH = 8'hFF;
  localparam logic [7:0]  RST_COUNT_LOW  = 8'hFF;
  localparam logic [7:0]  RST_PRESCALE   = 8'hFF;
  localparam logic [7:0]  RST_CONTROL    = 8'h12;
  localparam logic [7:0]  RST_GUARD      = 8'h7F;
  localparam logic [7:0]  RST_ROUTE      = 8'h06;
  localparam logic [15:0] GUARD_CONST    = 16'hFFFF;

  // refresh sequence bytes
  localparam logic [7:0] REFRESH_FIRST  = 8'hAA;
  localparam logic [7:0] REFRESH_SECOND = 8'h55;

  // internal clock divide ahead of the prescaler
  localparam int          INT_DIV      = 4;
  localparam logic [1:0]  INT_DIV_LAST = 2'(INT_DIV - 1);

  // input modes
  typedef enum logic [1:0] {
    TGU_EVENT   = 2'h0,
    TGU_GATED   = 2'h1,
    TGU_TRIGGER = 2'h2,
    TGU_RETRIG  = 2'h3
  } tgu_mode_t;

  // counter run state, one-hot
  typedef enum logic [2:0] {
    TGU_IDLE  = 3'b001,
    TGU_ARMED = 3'b010,
    TGU_COUNT = 3'b100
  } tgu_state_t;

  // avalon slave request bundle
  typedef struct packed {
    logic [4:0] address;
    logic       read;
    logic       write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } tgu_req_t;

  // control register fields
  typedef struct packed {
    logic      run;
    logic      single;
    tgu_mode_t mode;
    logic      in_en;
    logic      out_mode;
    logic      wr_out;
    logic      out_en;
  } tgu_ctrl_t;

endpackage

// file: tgu_timer.sv
// file: timer/guard unit, 16-bit down-counter with prescaler, waveform output and guard reset
//
// Function
// R1: 16-bit down-counter behind 8-bit prescaler
// R2: input enable picks pin pulses, else clock/4
// R3: run bit starts next cycle, clear halts
// R4: restart resumes held count unless rewritten
// R5: running: constant at end, prescaler immediate
// R6: end of count when counter hits zero
// R7: single mode stops, reloads, clears run bit
// R8: continuous mode reloads and keeps counting
// R9: single bit and run bit writable together
// R10: event mode counts falling input edges
// R11: source spaces event edges by eight clocks; the tgu_partner fall task spaces them ten clocks apart
// R12: gated mode counts only while pin high
// R13: triggerable mode starts on edge after run
// R14: retriggerable edge reloads; ignored when stopped
// R15: output disabled drives pin high
// R16: square mode toggles output each end
// R17: pwm mode copies write-out bit each end
// R18: select pin low forces guard after reset
// R19: clearing guard enable enters guard, locks
// R20: guard mode: only prescaler writes; end resets
// R21: AAh then 55h to low register refreshes
// R22: guard ignores run, single, mode; continuous
// R23: two-bit input mode field encoding
// R24: prescaler divides by value plus one
// R25: routing bits select interrupt sources
// R26: run bit readable at any time
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module tgu_timer (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        TIMER_INPUT_PIN,
  input  wire logic        HW_SW_GUARD_SELECT_PIN,
  input  wire logic        EXT_IRQ0_PIN,
  input  wire logic        NMI_PIN,
  output logic             TIMER_OUTPUT_PIN,
  output logic             SYSTEM_RESET,
  output logic             IRQ_TOP_LEVEL,
  output logic             IRQ_CHANNEL_A0
);
  import tgu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_meta;      // reset release stage one
  logic       rst_n;         // synchronised reset
  logic [1:0] in_sync;       // timer input synchroniser
  logic [1:0] sel_sync;      // guard select synchroniser
  logic       in_prev;       // last synchronised input
  logic       hw_guard;      // strap caught after release
  logic       strap_done;    // strap capture done

  // reset release through two flops
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // input synchroniser, reset to the idle high level so reset makes no false edge
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      in_sync <= 2'h3;
      in_prev <= 1'b1;
    end else begin
      in_sync <= {in_sync[0], TIMER_INPUT_PIN};
      in_prev <= in_sync[1];
    end
  end

  // strap synchroniser runs through reset, so the strap is settled at capture
  always_ff @(posedge MCLK) begin
    sel_sync <= {sel_sync[0], HW_SW_GUARD_SELECT_PIN};
  end

  // strap capture once after each external reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hw_guard   <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done && rst_n) begin
      hw_guard   <= ~sel_sync[1]; // R18
      strap_done <= 1'b1;
    end
  end

  logic pin_in;    // synchronised input level
  logic fall_edge; // input falling edge
  assign pin_in    = in_sync[1];
  assign fall_edge = in_prev & ~in_sync[1]; // R10

  ////////////////////////////////////////////////////////////////////////////
  // register file state

  logic [15:0] constant;       // reload constant
  logic [7:0]  prescale;       // prescaler value
  tgu_ctrl_t   ctrl;           // control fields
  logic        guard_en_n;     // guard enable, active low
  logic        top_sel;        // top level source select
  logic        a0_sel;         // channel a0 source select
  logic        const_dirty;    // constant rewritten since last load
  logic        refresh_armed;  // first refresh byte seen
  logic [15:0] count;          // down-counter
  logic [7:0]  pre_cnt;        // prescaler counter
  logic [1:0]  div_cnt;        // clock/4 divider
  tgu_state_t  state;          // run state
  logic        out_q;          // output latch
  logic        sys_rst;        // guard reset pulse

  logic [15:0] next_constant;
  logic [7:0]  next_prescale;
  tgu_ctrl_t   next_ctrl;
  logic        next_guard_en_n;
  logic        next_top_sel;
  logic        next_a0_sel;
  logic        next_const_dirty;
  logic        next_refresh_armed;
  logic [15:0] next_count;
  logic [7:0]  next_pre_cnt;
  logic [1:0]  next_div_cnt;
  tgu_state_t  next_state;
  logic        next_out_q;
  logic        next_sys_rst;
  logic [31:0] next_readdata;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: single-cycle writes, one wait cycle on reads

  logic wr;      // write accepted this cycle
  logic rd_done; // read data ready
  logic be0;     // low byte lane enabled
  logic guard;   // guard mode active

  assign be0   = AVS_BYTEENABLE[0];
  assign wr    = AVS_WRITE & be0;
  assign guard = hw_guard | ~guard_en_n;

  // reads wait one cycle for registered data, writes never wait
  assign AVS_WAITREQUEST = AVS_READ & ~rd_done;

  logic wr_high, wr_low, wr_pre, wr_ctrl, wr_guard, wr_route;
  assign wr_high  = wr && AVS_ADDRESS == 5'(OFS_COUNT_HIGH);
  assign wr_low   = wr && AVS_ADDRESS == 5'(OFS_COUNT_LOW);
  assign wr_pre   = wr && AVS_ADDRESS == 5'(OFS_PRESCALE);
  assign wr_ctrl  = wr && AVS_ADDRESS == 5'(OFS_CONTROL);
  assign wr_guard = wr && AVS_ADDRESS == OFS_GUARD;
  assign wr_route = wr && AVS_ADDRESS == OFS_ROUTE;

  ////////////////////////////////////////////////////////////////////////////
  // tick generation

  logic base_tick;   // clock/4 or pin pulse into prescaler
  logic gate_ok;     // count permission this tick
  logic pre_tick;    // prescaler terminal tick
  logic eoc;         // end of count this cycle
  logic use_pin;     // prescaler fed by pin pulses
  logic [7:0] wdata; // low write byte

  assign wdata    = AVS_WRITEDATA[7:0];
  // R22: guard mode always counts the internal clock
  assign use_pin  = ~guard & ctrl.in_en & (ctrl.mode == TGU_EVENT); // R22
  // R2
  assign base_tick = use_pin ? fall_edge : (div_cnt == INT_DIV_LAST);
  assign gate_ok  = guard | (state == TGU_COUNT &&
                    (!ctrl.in_en || ctrl.mode != TGU_GATED || pin_in)); // R12
  assign pre_tick = base_tick && gate_ok && pre_cnt == 8'h00; // R24
  assign eoc      = pre_tick && count == 16'h0000; // R6

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for registers, counter and output

  always_comb begin
    next_constant      = constant;
    next_prescale      = prescale;
    next_ctrl          = ctrl;
    next_guard_en_n    = guard_en_n;
    next_top_sel       = top_sel;
    next_a0_sel        = a0_sel;
    next_const_dirty   = const_dirty;
    next_refresh_armed = refresh_armed;
    next_count         = count;
    next_pre_cnt       = pre_cnt;
    next_div_cnt       = div_cnt + 2'h1;
    next_state         = state;
    next_out_q         = out_q;
    next_sys_rst       = 1'b0;

    // software writes
    if (wr_pre) begin
      next_prescale = wdata; // R5 R20
      next_pre_cnt  = wdata;
    end
    if (!guard) begin
      if (wr_high) begin
        next_constant[15:8] = wdata;
        next_const_dirty    = 1'b1; // R4
      end
      if (wr_low) begin
        next_constant[7:0] = wdata;
        next_const_dirty   = 1'b1;
      end
      if (wr_ctrl) begin
        next_ctrl = tgu_ctrl_t'(wdata); // R9
      end
    end
    if (wr_route) begin
      next_top_sel = wdata[BIT_TOP_SEL];
      next_a0_sel  = wdata[BIT_A0_SEL];
    end
    // clear only, never set again
    if (wr_guard && !wdata[BIT_GUARD_EN_N]) begin
      next_guard_en_n = 1'b0; // R19
    end
    if (hw_guard) begin
      next_constant = GUARD_CONST; // R18
    end

    if (guard) begin
      // guard mode: continuous on clock/4
      if (wr_low) begin
        next_refresh_armed = (wdata == REFRESH_FIRST); // R21
        if (refresh_armed && wdata == REFRESH_SECOND) begin
          next_count   = constant; // R21
          next_pre_cnt = prescale;
        end
      end
      if (state != TGU_COUNT) begin
        next_state = TGU_COUNT; // R19
        next_count = constant;
      end else if (pre_tick && !(wr_low && refresh_armed && wdata == REFRESH_SECOND)) begin
        next_pre_cnt = prescale;
        if (eoc) begin
          next_sys_rst = 1'b1; // R20
          next_count   = constant;
        end else begin
          next_count = count - 16'h0001;
        end
      end else if (base_tick && !wr_pre) begin
        next_pre_cnt = pre_cnt - 8'h01;
      end
    end else begin
      case (state)
        TGU_IDLE: begin
          if (ctrl.run) begin
            if (const_dirty) begin
              next_count       = constant; // R4
              // a constant written in this very cycle stays pending
              next_const_dirty = wr_high | wr_low;
            end
            // R10 R13: wait for an edge before counting
            if (ctrl.in_en && (ctrl.mode == TGU_EVENT || ctrl.mode == TGU_TRIGGER)) begin // R23
              next_state = TGU_ARMED;
            end else begin
              next_state = TGU_COUNT; // R3
            end
          end
        end
        TGU_ARMED: begin
          if (!ctrl.run) begin
            next_state = TGU_IDLE;
          end else if (fall_edge) begin
            next_state = TGU_COUNT;
          end
        end
        TGU_COUNT: begin
          if (!ctrl.run) begin
            next_state = TGU_IDLE; // R3
          end else if (ctrl.in_en && ctrl.mode == TGU_RETRIG && fall_edge) begin
            next_count       = constant; // R14
            next_pre_cnt     = prescale;
            next_const_dirty = wr_high | wr_low;
          end else if (eoc) begin
            next_count       = constant; // R5 R8
            next_pre_cnt     = prescale;
            next_const_dirty = wr_high | wr_low; // R4
            if (ctrl.single) begin
              next_ctrl.run = 1'b0; // R7
              next_state    = TGU_IDLE;
            end
            next_out_q = ctrl.out_mode ? ctrl.wr_out : ~out_q; // R16 R17
          end else if (pre_tick) begin
            next_pre_cnt = prescale;
            next_count   = count - 16'h0001; // R1
          end else if (base_tick && gate_ok && !wr_pre) begin
            next_pre_cnt = pre_cnt - 8'h01;
          end
        end
        default: next_state = TGU_IDLE;
      endcase
    end
  end

  // read mux, registered
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      5'(OFS_COUNT_HIGH): next_readdata[7:0] = count[15:8];
      5'(OFS_COUNT_LOW):  next_readdata[7:0] = count[7:0];
      5'(OFS_PRESCALE):   next_readdata[7:0] = prescale;
      5'(OFS_CONTROL):    next_readdata[7:0] = ctrl; // R26
      OFS_GUARD:          next_readdata[BIT_GUARD_EN_N] = guard_en_n;
      OFS_ROUTE:          next_readdata[2:1] = {top_sel, a0_sel};
      default:            next_readdata = 32'h0000_0000;
    endcase
  end

  // state registers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      constant      <= {RST_COUNT_HIGH, RST_COUNT_LOW};
      prescale      <= RST_PRESCALE;
      ctrl          <= tgu_ctrl_t'(RST_CONTROL);
      guard_en_n    <= RST_GUARD[BIT_GUARD_EN_N];
      top_sel       <= RST_ROUTE[BIT_TOP_SEL];
      a0_sel        <= RST_ROUTE[BIT_A0_SEL];
      const_dirty   <= 1'b0;
      refresh_armed <= 1'b0;
      count         <= {RST_COUNT_HIGH, RST_COUNT_LOW};
      pre_cnt       <= RST_PRESCALE;
      div_cnt       <= 2'h0;
      state         <= TGU_IDLE;
      out_q         <= 1'b1;
      sys_rst       <= 1'b0;
      AVS_READDATA  <= 32'h0000_0000;
      rd_done       <= 1'b0;
    end else begin
      constant      <= next_constant;
      prescale      <= next_prescale;
      ctrl          <= next_ctrl;
      guard_en_n    <= next_guard_en_n;
      top_sel       <= next_top_sel;
      a0_sel        <= next_a0_sel;
      const_dirty   <= next_const_dirty;
      refresh_armed <= next_refresh_armed;
      count         <= next_count;
      pre_cnt       <= next_pre_cnt;
      div_cnt       <= next_div_cnt;
      state         <= next_state;
      out_q         <= next_out_q;
      sys_rst       <= next_sys_rst;
      AVS_READDATA  <= next_readdata;
      rd_done       <= AVS_READ & ~rd_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic eoc_q; // registered end of count for routing
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
    end else begin
      eoc_q <= eoc & ~guard;
    end
  end

  assign TIMER_OUTPUT_PIN = ctrl.out_en ? out_q : 1'b1; // R15
  assign SYSTEM_RESET     = sys_rst; // R20
  assign IRQ_TOP_LEVEL    = top_sel ? NMI_PIN : eoc_q; // R25
  assign IRQ_CHANNEL_A0   = a0_sel ? EXT_IRQ0_PIN : eoc_q; // R25

endmodule
`default_nettype wire

// file: tgu_timer_chk.sv
// checker: port-level properties of the timer/guard unit
`timescale 1ns/1ns
`default_nettype none
module tgu_chk
  import tgu_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        HW_SW_GUARD_SELECT_PIN,
  input wire logic        EXT_IRQ0_PIN,
  input wire logic        NMI_PIN,
  input wire logic        TIMER_OUTPUT_PIN,
  input wire logic        SYSTEM_RESET,
  input wire logic        IRQ_TOP_LEVEL,
  input wire logic        IRQ_CHANNEL_A0
);
  logic wr_lane;                                 // lane 0 write seen
  logic oe_q, a0_q, top_q, guard_q;              // shadows of out enable, routing, guard entry
  logic next_oe, next_a0, next_top, next_guard;  // their next values
  assign wr_lane = AVS_WRITE && AVS_BYTEENABLE[0];
  // shadow next values from observed writes
  always_comb begin
    next_oe    = oe_q;
    next_a0    = a0_q;
    next_top   = top_q;
    next_guard = guard_q;
    if (wr_lane && AVS_ADDRESS == 5'h0C && !guard_q && HW_SW_GUARD_SELECT_PIN) begin
      next_oe = AVS_WRITEDATA[BIT_OUT_EN];
    end
    if (wr_lane && AVS_ADDRESS == OFS_ROUTE) begin
      next_a0  = AVS_WRITEDATA[BIT_A0_SEL];
      next_top = AVS_WRITEDATA[BIT_TOP_SEL];
    end
    if (wr_lane && AVS_ADDRESS == OFS_GUARD && !AVS_WRITEDATA[BIT_GUARD_EN_N]) begin
      next_guard = 1'b1;
    end
  end
  // shadow registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      oe_q    <= RST_CONTROL[BIT_OUT_EN];
      a0_q    <= RST_ROUTE[BIT_A0_SEL];
      top_q   <= RST_ROUTE[BIT_TOP_SEL];
      guard_q <= 1'b0;
    end else begin
      oe_q    <= next_oe;
      a0_q    <= next_a0;
      top_q   <= next_top;
      guard_q <= next_guard;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  rd_wait_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST) else $error("read answered at once");
  rd_done_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("read stalls");
  wr_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST) else $error("write stalled");
  rd_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0) else $error("upper bits");
  guard_lock_a: assert property (guard_q && AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_GUARD
    |-> !AVS_READDATA[BIT_GUARD_EN_N]) else $error("guard enable set again");
  out_high_a: assert property (!oe_q |-> TIMER_OUTPUT_PIN) else $error("disabled output not high");
  rst_pulse_a: assert property (SYSTEM_RESET |=> !SYSTEM_RESET) else $error("reset pulse too long");
  rst_guard_a: assert property (!guard_q && HW_SW_GUARD_SELECT_PIN |-> !SYSTEM_RESET) else $error("stray reset");
  eoc_pulse_a: assert property (!a0_q && IRQ_CHANNEL_A0 |=> !IRQ_CHANNEL_A0) else $error("eoc pulse long");
  nmi_route_a: assert property (top_q |-> IRQ_TOP_LEVEL == NMI_PIN) else $error("top level route");
  pin_route_a: assert property (a0_q |-> IRQ_CHANNEL_A0 == EXT_IRQ0_PIN) else $error("a0 route");
endmodule
bind tgu_timer tgu_chk u_chk (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HW_SW_GUARD_SELECT_PIN(HW_SW_GUARD_SELECT_PIN),
  .EXT_IRQ0_PIN(EXT_IRQ0_PIN), .NMI_PIN(NMI_PIN), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .SYSTEM_RESET(SYSTEM_RESET),
  .IRQ_TOP_LEVEL(IRQ_TOP_LEVEL), .IRQ_CHANNEL_A0(IRQ_CHANNEL_A0));
`default_nettype wire

// file: tgu_timer_test.sv
// testbench of the timer/guard unit through its avalon port
`timescale 1ns/1ns
`default_nettype none
module tgu_timer_test;
  import tgu_pkg::*;
  logic        mclk = 1'b0;   // 25 MHz
  logic        rst_n = 1'b0;  // active low reset
  logic [4:0]  adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'hF;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        waitreq;
  logic        strap = 1'b1;  // high: software guard
  logic        irq0 = 1'b0;
  logic        nmi = 1'b0;
  logic        tin, tout, sysrst, irq_top, irq_a0;
  logic [7:0]  v, w;          // last read bytes
  int          err_count = 0;
  int          n_compared = 0;
  int          n_eoc = 0;     // end of count pulses seen on channel a0
  int          e0 = 0;        // pulse count at start of a test
  always #20 mclk = ~mclk;
  // count routed end of count pulses
  always @(posedge mclk) begin
    if (irq_a0 === 1'b1) begin
      n_eoc <= n_eoc + 1;
    end
  end
  tgu_timer DUT (.MCLK(mclk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
    .TIMER_INPUT_PIN(tin), .HW_SW_GUARD_SELECT_PIN(strap), .EXT_IRQ0_PIN(irq0), .NMI_PIN(nmi),
    .TIMER_OUTPUT_PIN(tout), .SYSTEM_RESET(sysrst), .IRQ_TOP_LEVEL(irq_top), .IRQ_CHANNEL_A0(irq_a0));
  tgu_partner u_far (.MCLK(mclk), .out_pin(tout), .sys_rst(sysrst), .in_pin(tin));
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic [4:0] a, input logic isw, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr  <= a;
    wdat <= {24'h0, d};
    rd   <= ~isw;
    wr   <= isw;
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      err_count++;
      $display("mismatch bus answer expected 0 seen %b", waitreq);
    end
    v = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic chk(input logic [4:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    cmp($sformatf("reg %h", a), {8'h0, e}, {8'h0, v});
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(5'h00, RST_COUNT_HIGH);
    chk(5'h04, RST_COUNT_LOW);
    chk(5'h08, RST_PRESCALE);
    chk(5'h0C, RST_CONTROL);
    chk(5'h10, 8'(RST_GUARD[BIT_GUARD_EN_N]) << BIT_GUARD_EN_N);
    chk(5'h14, RST_ROUTE);
    chk(5'h18, 8'h00);
    cmp("out pin", 16'h1, {15'h0, tout});
    nmi  <= 1'b1;
    irq0 <= 1'b1;
    repeat (2) @(posedge mclk);
    cmp("top irq", 16'h1, {15'h0, irq_top});
    cmp("a0 irq", 16'h1, {15'h0, irq_a0});
    nmi  <= 1'b0;
    irq0 <= 1'b0;
    tdone("reset");
    // continuous square wave on clock/4
    wr8(5'h14, 8'h00);
    wr8(5'h08, 8'h01);
    wr8(5'h00, 8'h00);
    wr8(5'h04, 8'h02);
    wr8(5'h0C, 8'h81);
    repeat (100) @(posedge mclk);
    cmp("period", 16'((2 + 1) * (1 + 1) * INT_DIV), u_far.gap);
    chk(5'h0C, 8'h81);
    wr8(5'h08, 8'h00);
    repeat (60) @(posedge mclk);
    cmp("period", 16'((2 + 1) * INT_DIV), u_far.gap);
    wr8(5'h04, 8'h05);
    repeat (80) @(posedge mclk);
    cmp("period", 16'((5 + 1) * INT_DIV), u_far.gap);
    tdone("square");
    // pwm output copies the write-out bit
    wr8(5'h0C, 8'h85);
    repeat (60) @(posedge mclk);
    cmp("pwm", 16'h0, {15'h0, tout});
    wr8(5'h0C, 8'h87);
    repeat (60) @(posedge mclk);
    cmp("pwm", 16'h1, {15'h0, tout});
    wr8(5'h0C, 8'h05);
    bus(5'h04, 1'b0, 8'h00);
    w = v;
    repeat (40) @(posedge mclk);
    chk(5'h04, w);
    be <= 4'hE;
    wr8(5'h08, 8'h33);
    be <= 4'hF;
    chk(5'h08, 8'h00);
    tdone("pwm");
    // single shot with constant changed while stopped
    wr8(5'h04, 8'h03);
    e0 = n_eoc;
    wr8(5'h0C, 8'hC0);
    chk(5'h0C, 8'hC0);
    repeat (40) @(posedge mclk);
    chk(5'h0C, 8'h40);
    chk(5'h04, 8'h03);
    cmp("eoc irq", 16'h1, 16'(n_eoc - e0));
    tdone("single");
    // event counting, gated, triggerable, retriggerable
    wr8(5'h04, 8'h01);
    wr8(5'h0C, 8'hC8);
    u_far.fall(1);
    chk(5'h0C, 8'hC8);
    u_far.fall(2);
    repeat (6) @(posedge mclk);
    chk(5'h0C, 8'h48);
    u_far.lvl(1'b0);
    wr8(5'h04, 8'h05);
    wr8(5'h0C, 8'hD8);
    repeat (40) @(posedge mclk);
    chk(5'h0C, 8'hD8);
    u_far.lvl(1'b1);
    repeat (40) @(posedge mclk);
    chk(5'h0C, 8'h58);
    wr8(5'h0C, 8'hE8);
    repeat (40) @(posedge mclk);
    chk(5'h0C, 8'hE8);
    u_far.fall(1);
    repeat (30) @(posedge mclk);
    chk(5'h0C, 8'h68);
    wr8(5'h0C, 8'hF8);
    u_far.fall(4);
    chk(5'h0C, 8'hF8);
    repeat (30) @(posedge mclk);
    chk(5'h0C, 8'h78);
    tdone("inputs");
    // software guard: lock, refresh, timeout
    wr8(5'h04, 8'h0F);
    wr8(5'h10, 8'h3F);
    wr8(5'h10, 8'h7F);
    bus(5'h10, 1'b0, 8'h00);
    cmp("guard enable", 16'h0, {15'h0, v[BIT_GUARD_EN_N]});
    wr8(5'h0C, 8'h00);
    chk(5'h0C, 8'h78);
    repeat (4) begin
      repeat (20) @(posedge mclk);
      wr8(5'h04, REFRESH_FIRST);
      wr8(5'h04, REFRESH_SECOND);
    end
    cmp("resets", 16'h0, u_far.rst_cnt);
    repeat (80) @(posedge mclk);
    cmp("resets", 16'h1, u_far.rst_cnt);
    tdone("soft guard");
    // hardware guard from the strap pin
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    wr8(5'h08, 8'h00);
    wr8(5'h00, 8'h00);
    chk(5'h00, 8'hFF);
    bus(5'h04, 1'b0, 8'h00);
    w = v;
    repeat (4) @(posedge mclk);
    bus(5'h04, 1'b0, 8'h00);
    cmp("free count", 16'h1, {15'h0, v != w});
    tdone("hard guard");
    end_sim();
  end
endmodule
`default_nettype wire
